/* rtl/scc_map.svh */
/*
 * Register offsets, field positions and reset values of the stabilisation
 * chain configuration bank. Included by scc_aux_sync, scc_bank and the bench.
 */
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SCC_ADDR_ROUTE 8'h5F
`define SCC_ADDR_IRQCFG 8'h6F
`define SCC_ADDR_CTRL1 8'h70
`define SCC_ADDR_CTRL2 8'h71

// ----------------------------------------
// Reset value, IRQCFG write mask and CTRL2 reserved-bit mask
// ----------------------------------------
`define SCC_RST_BYTE 8'h00
`define SCC_MASK_IRQCFG 8'hC0
`define SCC_MASK_CTRL2 8'h37

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCC_IRQ_DRDY 7
`define SCC_IRQ_LATCH 6
`define SCC_C1_BYTE_ORDER 7
`define SCC_C1_TRIGGER 6
`define SCC_C1_WIRE 5
`define SCC_C1_ACCEL_EN 4
`define SCC_C1_FS_HI 3
`define SCC_C1_FS_LO 2
`define SCC_C1_LOW_RANGE 1
`define SCC_C1_MASTER_EN 0
`define SCC_C2_HPM_HI 5
`define SCC_C2_HPM_LO 4
`define SCC_C2_LP_HI 2
`define SCC_C2_LP_LO 1
`define SCC_C2_HP_EN 0

`endif

/* rtl/scc_pkg.sv */
/*
 * Types of the stabilisation chain configuration bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package scc_pkg;
	typedef logic [7:0] scc_byte_t;
	// Gyro full scale of the stabilisation chain
	typedef enum logic [2:0] {
		SCC_FS_125,
		SCC_FS_250,
		SCC_FS_500,
		SCC_FS_1000,
		SCC_FS_2000
	} scc_fs_e;
	// High-pass cutoff choice
	typedef enum logic [1:0] {
		SCC_HP_16MHZ,
		SCC_HP_65MHZ,
		SCC_HP_RSVD,
		SCC_HP_1P04HZ
	} scc_hp_e;
	// Low-pass bandwidth choice at the fast data rate
	typedef enum logic [1:0] {
		SCC_LP_351HZ,
		SCC_LP_237HZ,
		SCC_LP_173HZ,
		SCC_LP_937HZ
	} scc_lp_e;
	// Data-enable mode of the gyro stabilisation path
	typedef enum logic [1:0] {
		SCC_DEN_OFF,
		SCC_DEN_TRIGGER,
		SCC_DEN_LATCHED
	} scc_den_e;
endpackage
`default_nettype wire

/* rtl/scc_wr_if.sv */
/*
 * Carries one write request from the auxiliary clock domain into the core
 * domain. Assumes a toggle-handshake producer and consumer.
 */
`timescale 1ns/1ns
`default_nettype none
interface scc_wr_if;
	logic [7:0] addr;
	logic [7:0] data;
	logic toggle;
	logic ack;
	modport src (output addr, output data, output toggle, input ack);
	modport dst (input addr, input data, input toggle, output ack);
endinterface
`default_nettype wire

/* rtl/scc_aux_sync.sv */
/*
 * Auxiliary-port side of the write crossing: holds a write from the
 * stabilisation controller and hands it over by toggle handshake.
 * Assumes auxClk is the aux port clock; writes arrive as one-cycle strobes.
 */
`timescale 1ns/1ns
`default_nettype none
`include "scc_map.svh"
module scc_aux_sync (
	input wire logic auxClk,
	input wire logic arst_n,
	input wire logic auxWrEn,
	input wire logic [7:0] auxAddr,
	input wire logic [7:0] auxWrData,
	output logic auxBusy,
	scc_wr_if.src wr
);
	import scc_pkg::*;

	logic [7:0] addr_q, addr_d;
	logic [7:0] data_q, data_d;
	logic tog_q, tog_d;
	logic ackMeta_q, ackSync_q;

	// ----------------------------------------
	// Ack synchroniser
	// ----------------------------------------
	always_ff @(posedge auxClk or negedge arst_n) begin
		if (!arst_n) begin
			ackMeta_q <= 1'b0;
			ackSync_q <= 1'b0;
		end else begin
			ackMeta_q <= wr.ack;
			ackSync_q <= ackMeta_q;
		end
	end

	// Busy while the core has not echoed the toggle; a write then is dropped
	assign auxBusy = tog_q != ackSync_q;

	// Capture a new write only when idle so data stays stable across crossing
	always_comb begin
		addr_d = addr_q;
		data_d = data_q;
		tog_d = tog_q;
		if (auxWrEn && !auxBusy) begin
			addr_d = auxAddr;
			data_d = auxWrData;
			tog_d = ~tog_q;
		end
	end

	always_ff @(posedge auxClk or negedge arst_n) begin
		if (!arst_n) begin
			addr_q <= `SCC_RST_BYTE;
			data_q <= `SCC_RST_BYTE;
			tog_q <= 1'b0;
		end else begin
			addr_q <= addr_d;
			data_q <= data_d;
			tog_q <= tog_d;
		end
	end

	assign wr.addr = addr_q;
	assign wr.data = data_q;
	assign wr.toggle = tog_q;
endmodule
`default_nettype wire

/* rtl/scc_bank.sv */
/*
 * Stabilisation chain configuration and second interrupt pin routing.
 * The primary interface reads all four registers and writes only the
 * routing register; the auxiliary port (own clock) writes the rest.
 * Assumes event inputs and data-ready come from core_clk logic.
 */
`timescale 1ns/1ns
`default_nettype none
`include "scc_map.svh"

module scc_bank (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic priWrEn,
	input wire logic priRdEn,
	input wire logic [7:0] priAddr,
	input wire logic [7:0] priWrData,
	output logic [7:0] priRdData,
	output logic priRdValid,
	input wire logic auxClk,
	input wire logic auxWrEn,
	input wire logic [7:0] auxAddr,
	input wire logic [7:0] auxWrData,
	output logic auxWrBusy,
	input wire logic [7:0] motionEvents,
	input wire logic stabDataReady,
	input wire logic primaryGyroHpEnable,
	input wire logic [15:0] gyroSample,
	output logic secondIrqPin,
	output logic [7:0] outLowAddrByte,
	output logic [7:0] outHighAddrByte,
	output logic auxThreeWire,
	output logic stabChainEnable,
	output logic gyroStabEnable,
	output logic accelStabEnable,
	output logic firstLowpassToStab,
	output scc_pkg::scc_fs_e gyroStabFullScale,
	output logic gyroStabHpActive,
	output scc_pkg::scc_hp_e gyroStabHpCutoff,
	output scc_pkg::scc_lp_e gyroStabLpType,
	output scc_pkg::scc_den_e gyroDenMode,
	output scc_pkg::scc_den_e accelDenMode,
	output logic ctrlTwoReservedSet
);
	import scc_pkg::*;

	scc_wr_if wrLink();

	// Raw busy output of the crossing and its registered copy, both in the aux domain only
	logic auxBusyRaw;
	logic auxBusy_q;

	// ----------------------------------------
	// Aux-domain write capture
	// ----------------------------------------
	scc_aux_sync uAuxSync (
		.auxClk(auxClk),
		.arst_n(arst_n),
		.auxWrEn(auxWrEn),
		.auxAddr(auxAddr),
		.auxWrData(auxWrData),
		.auxBusy(auxBusyRaw),
		.wr(wrLink.src)
	);

	// Busy registered in the aux domain so the output is a flip-flop
	always_ff @(posedge auxClk or negedge arst_n) begin
		if (!arst_n) begin
			auxBusy_q <= 1'b0;
		end else begin
			auxBusy_q <= auxBusyRaw;
		end
	end
	assign auxWrBusy = auxBusy_q;

	// ----------------------------------------
	// Core-side toggle synchroniser
	// ----------------------------------------
	logic togMeta_q, togSync_q, togSeen_q;
	logic ack_q, ack_d;
	logic auxWrite;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			togMeta_q <= 1'b0;
			togSync_q <= 1'b0;
		end else begin
			togMeta_q <= wrLink.toggle;
			togSync_q <= togMeta_q;
		end
	end

	// Address and data are stable while the toggle differs, so no sync needed
	assign auxWrite = togSync_q != togSeen_q;
	assign ack_d = auxWrite ? togSync_q : ack_q;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			togSeen_q <= 1'b0;
			ack_q <= 1'b0;
		end else begin
			togSeen_q <= togSync_q;
			ack_q <= ack_d;
		end
	end
	// Echoed toggle frees the aux side for its next write
	assign wrLink.ack = ack_q;

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	scc_byte_t route_q, route_d;
	scc_byte_t irqCfg_q, irqCfg_d;
	scc_byte_t ctrl1_q, ctrl1_d;
	scc_byte_t ctrl2_q, ctrl2_d;

	// Primary port owns routing; aux owns the stabilisation bank
	always_comb begin
		route_d = route_q;
		irqCfg_d = irqCfg_q;
		ctrl1_d = ctrl1_q;
		ctrl2_d = ctrl2_q;
		if (priWrEn && priAddr == `SCC_ADDR_ROUTE) begin
			route_d = priWrData;
		end
		// Primary writes elsewhere fall through untouched
		if (auxWrite) begin
			unique case (wrLink.addr)
				`SCC_ADDR_IRQCFG: irqCfg_d = wrLink.data & `SCC_MASK_IRQCFG;
				`SCC_ADDR_CTRL1: ctrl1_d = wrLink.data;
				// Stored as written so a reserved-bit slip stays visible
				`SCC_ADDR_CTRL2: ctrl2_d = wrLink.data;
				default: ctrl2_d = ctrl2_q;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			route_q <= `SCC_RST_BYTE;
			irqCfg_q <= `SCC_RST_BYTE;
			ctrl1_q <= `SCC_RST_BYTE;
			ctrl2_q <= `SCC_RST_BYTE;
		end else begin
			route_q <= route_d;
			irqCfg_q <= irqCfg_d;
			ctrl1_q <= ctrl1_d;
			ctrl2_q <= ctrl2_d;
		end
	end

	// ----------------------------------------
	// Primary read port
	// ----------------------------------------
	scc_byte_t rdData_d;
	logic rdValid_d;

	// Unmapped addresses read as zero; one cycle of latency
	always_comb begin
		rdValid_d = priRdEn;
		rdData_d = `SCC_RST_BYTE;
		if (priRdEn) begin
			unique case (priAddr)
				`SCC_ADDR_ROUTE: rdData_d = route_q;
				`SCC_ADDR_IRQCFG: rdData_d = irqCfg_q;
				`SCC_ADDR_CTRL1: rdData_d = ctrl1_q;
				`SCC_ADDR_CTRL2: rdData_d = ctrl2_q;
				default: rdData_d = `SCC_RST_BYTE;
			endcase
		end
	end

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic scc_fs_e fsDecode(input logic lowRange, input logic [1:0] fs);
		scc_fs_e r;
		r = SCC_FS_250;
		if (lowRange) begin
			r = SCC_FS_125;
		end else begin
			unique case (fs)
				2'h0: r = SCC_FS_250;
				2'h1: r = SCC_FS_500;
				2'h2: r = SCC_FS_1000;
				2'h3: r = SCC_FS_2000;
			endcase
		end
		return r;
	endfunction

	function automatic scc_den_e denDecode(input logic trig, input logic latch);
		scc_den_e r;
		r = SCC_DEN_OFF;
		// Combinations 00 and 01 leave data-enable off
		if (trig && latch) begin
			r = SCC_DEN_LATCHED;
		end else if (trig) begin
			r = SCC_DEN_TRIGGER;
		end
		return r;
	endfunction

	// ----------------------------------------
	// Derived configuration, all registered
	// ----------------------------------------
	logic masterEn;
	logic irq_q, irq_d;
	logic [7:0] lowB_q, lowB_d, highB_q, highB_d;
	logic [15:0] samp_q;
	logic hpMeta_q, hpSync_q;
	logic cfgWire_q, cfgChain_q, cfgGyro_q, cfgAccel_q, cfgLpf_q, cfgHp_q, cfgRsvd_q;
	logic cfgWire_d, cfgChain_d, cfgGyro_d, cfgAccel_d, cfgLpf_d, cfgHp_d, cfgRsvd_d;
	scc_fs_e cfgFs_q, cfgFs_d;
	scc_hp_e cfgHpm_q, cfgHpm_d;
	scc_lp_e cfgLp_q, cfgLp_d;
	scc_den_e cfgDen_q, cfgDen_d;

	assign masterEn = ctrl1_q[`SCC_C1_MASTER_EN];

	// Data-ready override beats every routing bit
	always_comb begin
		irq_d = |(route_q & motionEvents);
		if (irqCfg_q[`SCC_IRQ_DRDY]) begin
			irq_d = stabDataReady;
		end
	end

	// Byte order of the gyro output word on the aux port
	always_comb begin
		lowB_d = samp_q[7:0];
		highB_d = samp_q[15:8];
		if (ctrl1_q[`SCC_C1_BYTE_ORDER]) begin
			lowB_d = samp_q[15:8];
			highB_d = samp_q[7:0];
		end
	end

	// Primary high-pass level may come from another block; resync is cheap
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			hpMeta_q <= 1'b0;
			hpSync_q <= 1'b0;
		end else begin
			hpMeta_q <= primaryGyroHpEnable;
			hpSync_q <= hpMeta_q;
		end
	end

	// Configuration decode; outputs follow the registers one cycle later
	always_comb begin
		cfgWire_d = ctrl1_q[`SCC_C1_WIRE];
		cfgChain_d = masterEn;
		cfgGyro_d = masterEn;
		cfgAccel_d = masterEn && ctrl1_q[`SCC_C1_ACCEL_EN];
		cfgLpf_d = masterEn;
		// Primary high-pass owns the filter, so the aux chain loses it
		cfgHp_d = ctrl2_q[`SCC_C2_HP_EN] && !hpSync_q;
		cfgRsvd_d = |(ctrl2_q & ~`SCC_MASK_CTRL2);
		cfgFs_d = fsDecode(ctrl1_q[`SCC_C1_LOW_RANGE],
			ctrl1_q[`SCC_C1_FS_HI:`SCC_C1_FS_LO]);
		cfgHpm_d = scc_hp_e'(ctrl2_q[`SCC_C2_HPM_HI:`SCC_C2_HPM_LO]);
		cfgLp_d = scc_lp_e'(ctrl2_q[`SCC_C2_LP_HI:`SCC_C2_LP_LO]);
		cfgDen_d = denDecode(ctrl1_q[`SCC_C1_TRIGGER], irqCfg_q[`SCC_IRQ_LATCH]);
	end

	// Every top-level output but auxWrBusy and accelDenMode, and the read port, come straight from here
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			samp_q <= {2{`SCC_RST_BYTE}};
			irq_q <= 1'b0;
			lowB_q <= `SCC_RST_BYTE;
			highB_q <= `SCC_RST_BYTE;
			priRdData <= `SCC_RST_BYTE;
			priRdValid <= 1'b0;
			cfgWire_q <= 1'b0;
			cfgChain_q <= 1'b0;
			cfgGyro_q <= 1'b0;
			cfgAccel_q <= 1'b0;
			cfgLpf_q <= 1'b0;
			cfgHp_q <= 1'b0;
			cfgRsvd_q <= 1'b0;
			cfgFs_q <= SCC_FS_250;
			cfgHpm_q <= SCC_HP_16MHZ;
			cfgLp_q <= SCC_LP_351HZ;
			cfgDen_q <= SCC_DEN_OFF;
		end else begin
			samp_q <= gyroSample;
			irq_q <= irq_d;
			lowB_q <= lowB_d;
			highB_q <= highB_d;
			priRdData <= rdData_d;
			priRdValid <= rdValid_d;
			cfgWire_q <= cfgWire_d;
			cfgChain_q <= cfgChain_d;
			cfgGyro_q <= cfgGyro_d;
			cfgAccel_q <= cfgAccel_d;
			cfgLpf_q <= cfgLpf_d;
			cfgHp_q <= cfgHp_d;
			cfgRsvd_q <= cfgRsvd_d;
			cfgFs_q <= cfgFs_d;
			cfgHpm_q <= cfgHpm_d;
			cfgLp_q <= cfgLp_d;
			cfgDen_q <= cfgDen_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign secondIrqPin = irq_q;
	assign outLowAddrByte = lowB_q;
	assign outHighAddrByte = highB_q;
	assign auxThreeWire = cfgWire_q;
	assign stabChainEnable = cfgChain_q;
	assign gyroStabEnable = cfgGyro_q;
	assign accelStabEnable = cfgAccel_q;
	assign firstLowpassToStab = cfgLpf_q;
	assign gyroStabFullScale = cfgFs_q;
	assign gyroStabHpActive = cfgHp_q;
	assign gyroStabHpCutoff = cfgHpm_q;
	assign gyroStabLpType = cfgLp_q;
	assign gyroDenMode = cfgDen_q;
	// Accelerometer path never sees data-enable gating
	assign accelDenMode = SCC_DEN_OFF;
	assign ctrlTwoReservedSet = cfgRsvd_q;
endmodule
`default_nettype wire

/* tb/scc_bank_sva.sv */
/* Port assertions for the stabilisation configuration bank.
   Assumes it is bound onto scc_bank and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module scc_bank_sva (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic priRdEn,
	input wire logic priRdValid,
	input wire logic auxClk,
	input wire logic auxWrEn,
	input wire logic auxWrBusy,
	input wire logic [7:0] motionEvents,
	input wire logic stabDataReady,
	input wire logic primaryGyroHpEnable,
	input wire logic [15:0] gyroSample,
	input wire logic secondIrqPin,
	input wire logic [7:0] outLowAddrByte,
	input wire logic [7:0] outHighAddrByte,
	input wire logic stabChainEnable,
	input wire logic gyroStabEnable,
	input wire logic accelStabEnable,
	input wire logic firstLowpassToStab,
	input wire logic gyroStabHpActive,
	input wire scc_pkg::scc_den_e accelDenMode
);
	import scc_pkg::*;
	logic [1:0] upCnt_q;
	logic [1:0] upCnt_d;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Age since reset, so a deep $past never looks into reset
	always_comb begin
		upCnt_d = (upCnt_q == 2'h3) ? upCnt_q : upCnt_q + 2'h1;
	end
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			upCnt_q <= 2'h0;
		end else begin
			upCnt_q <= upCnt_d;
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_read_answer: assert property (@(posedge core_clk) disable iff (!arst_n)
		priRdEn |=> priRdValid) else $error("read not answered");
	a_valid_cause: assert property (@(posedge core_clk) disable iff (!arst_n)
		priRdValid |-> $past(priRdEn)) else $error("read valid without request");
	a_pin_quiet: assert property (@(posedge core_clk) disable iff (!arst_n)
		(motionEvents == 8'h00 && !stabDataReady) [*2] |=> !secondIrqPin)
		else $error("second pin high with no source");
	a_accel_gate: assert property (@(posedge core_clk) disable iff (!arst_n)
		accelStabEnable |-> stabChainEnable) else $error("accel chain without master");
	a_master_fans: assert property (@(posedge core_clk) disable iff (!arst_n)
		stabChainEnable == (gyroStabEnable && firstLowpassToStab))
		else $error("master enable not fanned out");
	a_accel_noden: assert property (@(posedge core_clk) disable iff (!arst_n)
		accelDenMode == SCC_DEN_OFF) else $error("accel data-enable mode set");
	a_hp_blocked: assert property (@(posedge core_clk) disable iff (!arst_n)
		primaryGyroHpEnable [*8] |-> !gyroStabHpActive) else $error("stab high-pass active");
	a_byte_lanes: assert property (@(posedge core_clk) disable iff (!arst_n)
		upCnt_q == 2'h3 |-> (outLowAddrByte == $past(gyroSample[7:0], 2)
		&& outHighAddrByte == $past(gyroSample[15:8], 2))
		|| (outLowAddrByte == $past(gyroSample[15:8], 2)
		&& outHighAddrByte == $past(gyroSample[7:0], 2))) else $error("bytes misplaced");
	a_aux_busy: assert property (@(posedge auxClk) disable iff (!arst_n)
		auxWrEn && !auxWrBusy |-> ##[1:3] auxWrBusy) else $error("aux write not taken");
endmodule
bind scc_bank scc_bank_sva u_chk (.core_clk(core_clk), .arst_n(arst_n), .priRdEn(priRdEn),
	.priRdValid(priRdValid), .auxClk(auxClk), .auxWrEn(auxWrEn), .auxWrBusy(auxWrBusy),
	.motionEvents(motionEvents), .stabDataReady(stabDataReady),
	.primaryGyroHpEnable(primaryGyroHpEnable), .gyroSample(gyroSample),
	.secondIrqPin(secondIrqPin), .outLowAddrByte(outLowAddrByte),
	.outHighAddrByte(outHighAddrByte), .stabChainEnable(stabChainEnable),
	.gyroStabEnable(gyroStabEnable), .accelStabEnable(accelStabEnable),
	.firstLowpassToStab(firstLowpassToStab), .gyroStabHpActive(gyroStabHpActive),
	.accelDenMode(accelDenMode));
`default_nettype wire

/* tb/scc_aux_model.sv */
/* Stabilisation controller model on the aux write port.
   Assumes auxClk comes from the bench and busy is on auxClk. */
`timescale 1ns/1ns
`default_nettype none
module scc_aux_model (
	input wire logic auxClk,
	input wire logic auxWrBusy,
	output logic auxWrEn,
	output logic [7:0] auxAddr,
	output logic [7:0] auxWrData
);
	initial begin
		auxWrEn = 1'b0;
		auxAddr = 8'h00;
		auxWrData = 8'h00;
	end
	// One write; raw lets a scenario break the reserved-zero bits
	task automatic write(input logic [7:0] a, input logic [7:0] d, input bit raw);
		int n = 0;
		@(posedge auxClk);
		while (auxWrBusy !== 1'b0 && n < 60) begin
			@(posedge auxClk);
			n++;
		end
		auxWrEn <= 1'b1;
		auxAddr <= a;
		auxWrData <= (a == 8'h71 && !raw) ? (d & 8'h37) : d;
		@(posedge auxClk);
		auxWrEn <= 1'b0;
		// Released lines show junk, not the last value
		auxAddr <= ~a;
		auxWrData <= ~d;
		// Busy lags the strobe, so give it two edges before polling
		repeat (2) @(posedge auxClk);
		while (auxWrBusy !== 1'b0 && n < 120) begin
			@(posedge auxClk);
			n++;
		end
	endtask
endmodule
`default_nettype wire

/* tb/tb_scc_bank.sv */
/* Self-checking bench for the stabilisation configuration bank.
   Assumes the aux model in scc_aux_model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
`include "scc_map.svh"
module tb_scc_bank;
	import scc_pkg::*;
	logic core_clk = 1'b0;
	logic auxClk = 1'b0;
	logic arst_n = 1'b0;
	logic priWrEn = 1'b0;
	logic priRdEn = 1'b0;
	logic [7:0] priAddr = 8'h00;
	logic [7:0] priWrData = 8'h00;
	logic [7:0] motionEvents = 8'h00;
	logic stabDataReady = 1'b0;
	logic primaryGyroHpEnable = 1'b0;
	logic [15:0] gyroSample = 16'h0000;
	logic [7:0] priRdData, auxAddr, auxWrData, outLowAddrByte, outHighAddrByte;
	logic priRdValid, auxWrEn, auxWrBusy, secondIrqPin, auxThreeWire, stabChainEnable;
	logic gyroStabEnable, accelStabEnable, firstLowpassToStab, gyroStabHpActive;
	logic ctrlTwoReservedSet;
	scc_fs_e gyroStabFullScale;
	scc_hp_e gyroStabHpCutoff;
	scc_lp_e gyroStabLpType;
	scc_den_e gyroDenMode, accelDenMode;
	int error_cnt = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [7:0] b, d, e;
	logic l;
	// Mapped registers, then one unmapped address
	logic [7:0] regAddr [5] = '{8'h5F, 8'h6F, 8'h70, 8'h71, 8'h3C};
	logic [7:0] ctrlCorner [8] = '{8'h01, 8'h05, 8'h09, 8'h0D, 8'h03, 8'h1F, 8'hF1, 8'h40};
	// ----------------------------------------
	// Clocks, design and far side
	// ----------------------------------------
	always #5 core_clk = ~core_clk;
	// Aux clock offset so its edges drift against the core clock
	initial begin
		#7;
		forever #16 auxClk = ~auxClk;
	end
	scc_bank u_dut (.core_clk(core_clk), .arst_n(arst_n), .priWrEn(priWrEn),
		.priRdEn(priRdEn), .priAddr(priAddr), .priWrData(priWrData), .priRdData(priRdData),
		.priRdValid(priRdValid), .auxClk(auxClk), .auxWrEn(auxWrEn), .auxAddr(auxAddr),
		.auxWrData(auxWrData), .auxWrBusy(auxWrBusy), .motionEvents(motionEvents),
		.stabDataReady(stabDataReady), .primaryGyroHpEnable(primaryGyroHpEnable),
		.gyroSample(gyroSample), .secondIrqPin(secondIrqPin), .outLowAddrByte(outLowAddrByte),
		.outHighAddrByte(outHighAddrByte), .auxThreeWire(auxThreeWire),
		.stabChainEnable(stabChainEnable), .gyroStabEnable(gyroStabEnable),
		.accelStabEnable(accelStabEnable), .firstLowpassToStab(firstLowpassToStab),
		.gyroStabFullScale(gyroStabFullScale), .gyroStabHpActive(gyroStabHpActive),
		.gyroStabHpCutoff(gyroStabHpCutoff), .gyroStabLpType(gyroStabLpType),
		.gyroDenMode(gyroDenMode), .accelDenMode(accelDenMode),
		.ctrlTwoReservedSet(ctrlTwoReservedSet));
	scc_aux_model u_aux (.auxClk(auxClk), .auxWrBusy(auxWrBusy), .auxWrEn(auxWrEn),
		.auxAddr(auxAddr), .auxWrData(auxWrData));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic wrap_up();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic pri_wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk);
		priWrEn <= 1'b1;
		priAddr <= a;
		priWrData <= v;
		@(posedge core_clk);
		priWrEn <= 1'b0;
	endtask
	task automatic pri_rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge core_clk);
		priRdEn <= 1'b1;
		priAddr <= a;
		@(posedge core_clk);
		priRdEn <= 1'b0;
		#1;
		chk({7'h00, priRdValid}, 8'h01);
		v = priRdData;
	endtask
	task automatic aux(input logic [7:0] a, input logic [7:0] v);
		u_aux.write(a, v, 1'b0);
		repeat (4) @(posedge core_clk);
	endtask
	// Registered outputs need three edges to reflect new inputs
	task automatic settle();
		repeat (3) @(posedge core_clk);
		#1;
	endtask
	function automatic logic [7:0] exp_fs(input logic [7:0] c);
		return c[1] ? 8'(SCC_FS_125) : 8'(c[3:2]) + 8'(SCC_FS_250);
	endfunction
	function automatic logic [7:0] exp_den(input logic t, input logic h);
		return t ? (h ? 8'(SCC_DEN_LATCHED) : 8'(SCC_DEN_TRIGGER)) : 8'(SCC_DEN_OFF);
	endfunction
	// Cut a hang short well beyond the expected run length
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 40000) begin
			error_cnt++;
			wrap_up();
		end
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		void'($urandom(53));
		repeat (16) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		// Reset values, plus an unmapped address
		foreach (regAddr[i]) begin
			pri_rd(regAddr[i], d);
			chk(d, 8'h00);
		end
		// Primary writes land only in the routing register
		for (int i = 1; i < 4; i++) begin
			pri_wr(regAddr[i], 8'hFF);
			pri_rd(regAddr[i], d);
			chk(d, 8'h00);
		end
		// Each routing bit alone, then random masks against random events
		for (int i = 0; i < 28; i++) begin
			b = (i < 8) ? 8'h01 << i : 8'($urandom);
			e = (i < 8) ? 8'h01 << i : 8'($urandom);
			pri_wr(`SCC_ADDR_ROUTE, b);
			motionEvents <= e;
			settle();
			chk({7'h00, secondIrqPin}, {7'h00, |(b & e)});
			pri_rd(`SCC_ADDR_ROUTE, d);
			chk(d, b);
		end
		// Data-ready override beats every routed event
		aux(`SCC_ADDR_IRQCFG, 8'hFF);
		pri_rd(`SCC_ADDR_IRQCFG, d);
		chk(d, 8'hC0);
		pri_wr(`SCC_ADDR_ROUTE, 8'hFF);
		motionEvents <= 8'hFF;
		settle();
		chk({7'h00, secondIrqPin}, 8'h00);
		@(posedge core_clk);
		motionEvents <= 8'h00;
		stabDataReady <= 1'b1;
		settle();
		chk({7'h00, secondIrqPin}, 8'h01);
		aux(`SCC_ADDR_ROUTE, 8'h00);
		pri_rd(`SCC_ADDR_ROUTE, d);
		chk(d, 8'hFF);
		// First control register: corners then random bytes
		for (int i = 0; i < 16; i++) begin
			b = (i < 8) ? ctrlCorner[i[2:0]] : 8'($urandom);
			l = 1'($urandom);
			aux(`SCC_ADDR_IRQCFG, {1'b0, l, 6'h00});
			aux(`SCC_ADDR_CTRL1, b);
			gyroSample <= 16'($urandom);
			pri_wr(`SCC_ADDR_CTRL1, ~b);
			settle();
			chk(outLowAddrByte, b[7] ? gyroSample[15:8] : gyroSample[7:0]);
			chk(outHighAddrByte, b[7] ? gyroSample[7:0] : gyroSample[15:8]);
			chk({7'h00, auxThreeWire}, {7'h00, b[5]});
			chk({7'h00, accelStabEnable}, {7'h00, b[4] & b[0]});
			chk(8'(gyroStabFullScale), exp_fs(b));
			chk({5'h00, stabChainEnable, gyroStabEnable, firstLowpassToStab},
				{5'h00, b[0], b[0], b[0]});
			chk(8'(gyroDenMode), exp_den(b[6], l));
			chk(8'(accelDenMode), 8'(SCC_DEN_OFF));
			pri_rd(`SCC_ADDR_CTRL1, d);
			chk(d, b);
		end
		// Second control register over every cutoff and filter code
		for (int k = 0; k < 16; k++) begin
			b = {2'b00, k[3:2], 1'b0, k[1:0], k[0] ^ k[3]};
			@(posedge core_clk);
			primaryGyroHpEnable <= 1'($urandom);
			aux(`SCC_ADDR_CTRL2, b);
			settle();
			chk(8'(gyroStabHpCutoff), 8'(b[5:4]));
			chk(8'(gyroStabLpType), 8'(b[2:1]));
			chk({7'h00, gyroStabHpActive}, {7'h00, b[0] & !primaryGyroHpEnable});
			chk({7'h00, ctrlTwoReservedSet}, 8'h00);
		end
		// Controller decimating to 1 kHz, then 2 kHz, picks the advised cutoffs
		aux(`SCC_ADDR_CTRL2, 8'h04);
		settle();
		chk(8'(gyroStabLpType), 8'(SCC_LP_173HZ));
		aux(`SCC_ADDR_CTRL2, 8'h02);
		settle();
		chk(8'(gyroStabLpType), 8'(SCC_LP_237HZ));
		// A writer that breaks the reserved-zero bits is flagged
		u_aux.write(`SCC_ADDR_CTRL2, 8'hC9, 1'b1);
		settle();
		chk({7'h00, ctrlTwoReservedSet}, 8'h01);
		// Reset in mid-run clears every register and the reserved flag
		@(posedge core_clk);
		arst_n <= 1'b0;
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		chk({6'h00, ctrlTwoReservedSet, secondIrqPin}, 8'h00);
		foreach (regAddr[i]) begin
			pri_rd(regAddr[i], d);
			chk(d, 8'h00);
		end
		wrap_up();
	end
endmodule
`default_nettype wire
